// File: hw/rtcisp_dev.sv
// slave end of the rtc two-wire port: addressing, pointer, timeout
// Contract
// - match only address 1010010b, then acknowledge
// - address byte msb first, then direction bit
// - foreign address: release line, ignore transfer
// - data edge while clock high: start/stop
// - repeated start acts as stop plus start
// - 950 ms after start forces standby
// - after timeout: no ack, reads give FFh
// - pointer survives stop and timeout stop
// - first written byte loads the pointer
// - pointer advances after every data byte; a write byte refused for a full buffer leaves it unchanged
// - receiver acknowledges every received byte; the slave gives no ack to a write byte that meets a full buffer
// - master acknowledges bytes it wants more
// - master nack ends read; slave releases
// - acknowledger holds line low whole high
// - data changes only while clock low
// - eight bits plus ack; unlimited bytes
// - random read: address write, restart, read
// - plain read starts at last address plus one
// - write ends on stop or next start
// - slave never drives clock line
// - backup supply: release line, reset protocol
// - master finishes before backup, then stop/start
// - master starts only on idle bus
`timescale 1ns/1ps
module rtcisp_dev import rtcisp_pkg::*; #(
  parameter int unsigned TO_CYC = TIMEOUT_CYC, // bus timeout in cycles
  parameter int unsigned FIFO_DEPTH = 2 // write buffer words
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // power state, asynchronous to ref_clk
  input wire logic backup_supply_state,
  // serial link
  rtcisp_if.dev link,
  // register bank write side
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // register bank read side
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  localparam int unsigned TO_W = $clog2(TO_CYC + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TO_CYC - 1);
  // ==========================================================
  // parameter check
  if (TO_CYC < 2)
  begin : g_bad_to
    $error("rtcisp_dev: TO_CYC must be at least 2");
  end
  // protocol states
  typedef enum logic [2:0] {
    D_IDLE = 3'h1, // standby, line released
    D_RX = 3'h2, // receiving bytes
    D_TX = 3'h4 // sending read bytes
  } rtcisp_dst_e;
  rtcisp_dst_e state_q; // protocol state
  logic [2:0] scl_s; // clock synchroniser, [0] feeds [1] only
  logic [2:0] sda_s; // data synchroniser
  logic [1:0] bkp_s; // backup state synchroniser
  logic scl_rise; // clock rose
  logic scl_fall; // clock fell
  logic start_det; // start seen
  logic stop_det; // stop seen
  logic in_bkp; // backup supply active
  logic to_hit; // timeout reached this cycle
  logic ev_ok; // no overriding event this cycle
  logic busy_q; // between start and stop
  logic [TO_W-1:0] to_cnt_q; // time since start
  logic [3:0] bit_q; // bits done in byte
  logic [7:0] sh_q; // shift register
  logic addr_ph_q; // next byte is the address byte
  logic regad_ph_q; // next byte loads the pointer
  logic ack_ph_q; // inside the ack slot
  logic rd_q; // transfer is a read
  logic mack_q; // master acknowledged last byte
  logic oe_n_q; // data enable, low pulls the line
  logic [7:0] ptr_q; // register pointer
  logic push_valid; // write word offered to buffer
  logic push_ready; // buffer has room
  // ==========================================================
  // pin synchronisers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_s <= SYNC_HI;
      sda_s <= SYNC_HI;
      bkp_s <= '0;
    end
    else if (clk_en)
    begin
      scl_s <= {scl_s[1:0], link.scl};
      sda_s <= {sda_s[1:0], link.sda};
      bkp_s <= {bkp_s[0], backup_supply_state};
    end
  end
  // edges and conditions from synchronised levels only
  assign scl_rise = scl_s[1] && !scl_s[2];
  assign scl_fall = !scl_s[1] && scl_s[2];
  assign start_det = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
  assign stop_det = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];
  assign in_bkp = bkp_s[1];
  assign to_hit = busy_q && (to_cnt_q == TO_LAST);
  assign ev_ok = !in_bkp && !to_hit && !start_det && !stop_det;
  // ==========================================================
  // transfer timer: runs from start until stop, timeout or backup supply
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      to_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (in_bkp || stop_det || to_hit)
      begin
        busy_q <= 1'b0;
      end
      else if (start_det)
      begin
        busy_q <= 1'b1;
        to_cnt_q <= '0;
      end
      else if (busy_q)
      begin
        to_cnt_q <= to_cnt_q + TO_W'(1);
      end
    end
  end
  // ==========================================================
  // write words leave at the ack decision of a data byte
  assign push_valid = ev_ok && (state_q == D_RX) && scl_fall
    && (bit_q == BYTE_BITS) && !ack_ph_q && !addr_ph_q && !regad_ph_q;
  rtcisp_fifo #(
    .W(16),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({ptr_q, sh_q}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );
  assign rd_addr = ptr_q;
  // the slave only ever pulls the data line low; clock is input only
  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe_n = oe_n_q;
  // ==========================================================
  // protocol engine; the pointer is never touched by stop or timeout
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= D_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      addr_ph_q <= 1'b0;
      regad_ph_q <= 1'b0;
      ack_ph_q <= 1'b0;
      rd_q <= 1'b0;
      mack_q <= 1'b0;
      oe_n_q <= 1'b1;
      ptr_q <= PTR_RST;
    end
    else if (clk_en)
    begin
      if (in_bkp || to_hit)
      begin
        // standby: released line reads ones, writes go unanswered
        state_q <= D_IDLE;
        oe_n_q <= 1'b1;
      end
      else if (start_det)
      begin
        // a restart closes any transfer and opens a new one
        state_q <= D_RX;
        addr_ph_q <= 1'b1;
        regad_ph_q <= 1'b0;
        ack_ph_q <= 1'b0;
        rd_q <= 1'b0;
        bit_q <= '0;
        oe_n_q <= 1'b1;
      end
      else if (stop_det)
      begin
        state_q <= D_IDLE;
        oe_n_q <= 1'b1;
      end
      else
      begin
        case (state_q)
          D_RX:
          begin
            if (scl_rise && bit_q != BYTE_BITS)
            begin
              // sample on the rising clock, msb first
              sh_q <= {sh_q[6:0], sda_s[1]};
              bit_q <= bit_q + 4'h1;
            end
            else if (scl_fall && bit_q == BYTE_BITS && !ack_ph_q)
            begin
              // decide the ack; the line holds through the high phase
              ack_ph_q <= 1'b1;
              if (addr_ph_q)
              begin
                addr_ph_q <= 1'b0;
                if (sh_q[7:1] == DEV_ADDR)
                begin
                  oe_n_q <= 1'b0;
                  rd_q <= sh_q[0];
                  regad_ph_q <= !sh_q[0];
                end
                else
                begin
                  state_q <= D_IDLE;
                end
              end
              else if (regad_ph_q)
              begin
                ptr_q <= sh_q;
                regad_ph_q <= 1'b0;
                oe_n_q <= 1'b0;
              end
              else if (push_ready)
              begin
                ptr_q <= ptr_q + PTR_STEP;
                oe_n_q <= 1'b0;
              end
            end
            else if (scl_fall && ack_ph_q)
            begin
              // end of ack slot: release, or turn round for a read
              ack_ph_q <= 1'b0;
              bit_q <= '0;
              oe_n_q <= 1'b1;
              if (rd_q)
              begin
                state_q <= D_TX;
                sh_q <= rd_data;
                oe_n_q <= rd_data[7];
              end
            end
          end
          D_TX:
          begin
            if (scl_fall && bit_q < LAST_DBIT)
            begin
              sh_q <= {sh_q[6:0], 1'b1};
              oe_n_q <= sh_q[6];
              bit_q <= bit_q + 4'h1;
            end
            else if (scl_fall && bit_q == LAST_DBIT)
            begin
              oe_n_q <= 1'b1; // master owns the ack slot
              bit_q <= BYTE_BITS;
              ptr_q <= ptr_q + PTR_STEP;
            end
            else if (scl_rise && bit_q == BYTE_BITS)
            begin
              mack_q <= !sda_s[1];
            end
            else if (scl_fall && bit_q == BYTE_BITS)
            begin
              if (mack_q)
              begin
                sh_q <= rd_data;
                oe_n_q <= rd_data[7];
                bit_q <= '0;
              end
              else
              begin
                state_q <= D_IDLE;
              end
            end
          end
          D_IDLE:
          begin
            oe_n_q <= 1'b1;
          end
          default:
          begin
            state_q <= D_IDLE;
            oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule : rtcisp_dev

// File: hw/rtcisp_fifo.sv
// small valid/ready buffer that holds write words toward the register bank
`timescale 1ns/1ps
module rtcisp_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 2
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  // ==========================================================
  // parameter check: pointers wrap, so depth is a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("rtcisp_fifo: DEPTH must be a power of two, at least 2");
  end
  logic [W-1:0] mem_q [DEPTH]; // storage
  logic [PW-1:0] wp_q; // write pointer
  logic [PW-1:0] rp_q; // read pointer
  logic [PW:0] cnt_q; // words held
  logic push; // word taken this cycle
  logic pop; // word given this cycle
  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // ==========================================================
  // storage write, no reset needed on the data
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && push)
    begin
      mem_q[wp_q] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        wp_q <= wp_q + PW'(1);
      end
      if (pop)
      begin
        rp_q <= rp_q + PW'(1);
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + (PW+1)'(1);
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - (PW+1)'(1);
      end
    end
  end
endmodule : rtcisp_fifo

// File: hw/rtcisp_host.sv
// master end of the two-wire link: start, stop, byte write and byte read
`timescale 1ns/1ps
module rtcisp_host import rtcisp_pkg::*; #(
  parameter int unsigned QTR_CYC = SCL_QTR_CYC // cycles per quarter bit
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // serial link
  rtcisp_if.host link,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire rtcisp_op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  // answer port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  localparam int unsigned QW = $clog2(QTR_CYC);
  localparam logic [QW-1:0] Q_LAST = QW'(QTR_CYC - 1);
  // ==========================================================
  // parameter check
  if (QTR_CYC < 4)
  begin : g_bad_qtr
    $error("rtcisp_host: QTR_CYC must be at least 4");
  end
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, // waiting for a command
    H_START = 4'h2, // start or repeated start
    H_BIT = 4'h4, // nine bit slots of a byte
    H_STOP = 4'h8 // stop
  } rtcisp_hst_e;
  rtcisp_hst_e state_q; // sequencer state
  logic [QW-1:0] qcnt_q; // quarter timer
  logic tick; // quarter boundary
  logic [1:0] ph_q; // quarter within a step
  logic [3:0] bit_q; // bit slot
  logic [7:0] sh_q; // shift register
  logic rd_q; // byte is a read
  logic ackb_q; // ack to send after a read byte
  logic scl_q; // clock level, low pulls
  logic sda_q; // data level, low pulls
  logic [1:0] sda_s; // data synchroniser, [0] feeds [1] only
  assign tick = (qcnt_q == Q_LAST);
  assign cmd_ready = (state_q == H_IDLE);
  assign link.m_scl_o = 1'b0;
  assign link.m_scl_oe_n = scl_q;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe_n = sda_q;
  // ==========================================================
  // data line synchroniser and quarter timer
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sda_s <= 2'h3;
      qcnt_q <= '0;
    end
    else if (clk_en)
    begin
      sda_s <= {sda_s[0], link.sda};
      if (state_q == H_IDLE || tick)
      begin
        qcnt_q <= '0;
      end
      else
      begin
        qcnt_q <= qcnt_q + QW'(1);
      end
    end
  end
  // ==========================================================
  // sequencer: every step is four quarters
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= H_IDLE;
      ph_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      rd_q <= 1'b0;
      ackb_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_ack <= 1'b0;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'b0;
      if (tick)
      begin
        ph_q <= ph_q + 2'h1;
      end
      case (state_q)
        H_IDLE:
        begin
          ph_q <= '0;
          bit_q <= '0;
          if (cmd_valid)
          begin
            sh_q <= cmd_data;
            rd_q <= (cmd_op == OP_READ);
            ackb_q <= cmd_ack;
            case (cmd_op)
              OP_START: state_q <= H_START;
              OP_STOP: state_q <= H_STOP;
              default: state_q <= H_BIT;
            endcase
          end
        end
        H_START:
        begin
          // release data while clock low, raise clock, then pull data
          if (tick)
          begin
            case (ph_q)
              2'h0: sda_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b0;
              default:
              begin
                scl_q <= 1'b0;
                state_q <= H_IDLE;
              end
            endcase
          end
        end
        H_STOP:
        begin
          // data low, clock high, then data high with clock high
          if (tick)
          begin
            case (ph_q)
              2'h0: sda_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1;
              default: state_q <= H_IDLE;
            endcase
          end
        end
        H_BIT:
        begin
          if (tick)
          begin
            case (ph_q)
              2'h0:
              begin
                // data changes only while the clock is low
                if (bit_q != BYTE_BITS)
                begin
                  sda_q <= rd_q | sh_q[7];
                end
                else
                begin
                  sda_q <= !(rd_q && ackb_q);
                end
              end
              2'h1: scl_q <= 1'b1;
              2'h2:
              begin
                if (bit_q != BYTE_BITS)
                begin
                  sh_q <= {sh_q[6:0], sda_s[1]};
                end
                else
                begin
                  rsp_ack <= !sda_s[1];
                end
              end
              default:
              begin
                scl_q <= 1'b0;
                if (bit_q == BYTE_BITS)
                begin
                  rsp_valid <= 1'b1;
                  rsp_data <= sh_q;
                  state_q <= H_IDLE;
                end
                else
                begin
                  bit_q <= bit_q + 4'h1;
                end
              end
            endcase
          end
        end
        default:
        begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end
endmodule : rtcisp_host

// File: hw/rtcisp_if.sv
// two-wire link between master and slave, with wired-and line levels
`timescale 1ns/1ps
interface rtcisp_if;
  // ==========================================================
  // drivers: each pulls low when its enable is low and its data is low
  logic m_scl_o; // master clock data, always low
  logic m_scl_oe_n; // master clock enable, low pulls the line
  logic m_sda_o; // master data line value
  logic m_sda_oe_n; // master data enable, low drives
  logic s_sda_o; // slave data line value
  logic s_sda_oe_n; // slave data enable, low drives
  // resolved line levels, pulled up when nobody pulls low
  logic scl;
  logic sda;
  assign scl = !(!m_scl_oe_n && !m_scl_o);
  assign sda = !((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o));
  // ==========================================================
  // one view per party
  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe_n);
  modport host (
    input sda,
    output m_scl_o,
    output m_scl_oe_n,
    output m_sda_o,
    output m_sda_oe_n
  );
endinterface : rtcisp_if

// File: hw/rtcisp_pkg.sv
// shared constants and types of the rtc two-wire slave port and its master
package rtcisp_pkg;
  // ==========================================================
  // addressing
  localparam logic [6:0] DEV_ADDR = 7'h52; // fixed seven-bit bus address
  localparam logic [7:0] WR_ADDR_BYTE = 8'hA4; // address byte, write
  localparam logic [7:0] RD_ADDR_BYTE = 8'hA5; // address byte, read
  // ==========================================================
  // byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8; // bit count reaching ack slot
  localparam logic [3:0] LAST_DBIT = 4'h7; // index of the last data bit
  localparam logic [2:0] SYNC_HI = 3'h7; // idle-high synchroniser reset
  localparam logic [7:0] PTR_RST = 8'h00; // pointer value after reset
  localparam logic [7:0] PTR_STEP = 8'h01; // pointer advance per byte
  // ==========================================================
  // timing
  localparam int unsigned CLK_KHZ = 200000; // ref_clk rate in kHz
  localparam int unsigned TIMEOUT_MS = 950; // bus timeout in ms
  // timeout as a least time: whole cycles, exact at this rate
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned SCL_QTR_NS = 625; // quarter of the scl period
  // quarter period in cycles, rounded up
  localparam int unsigned SCL_QTR_CYC =
    (SCL_QTR_NS * (CLK_KHZ / 1000) + 999) / 1000;
  // ==========================================================
  // master primitive operations
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ = 2'h3
  } rtcisp_op_e;
endpackage : rtcisp_pkg

// File: verif/rtcisp_monitor.sv
// protocol checker watching the two-wire link between both ends
`timescale 1ns/1ps
module rtcisp_monitor import rtcisp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // framing state rebuilt from the lines
  logic scl_q, sda_q; // line levels one cycle ago
  logic first_q; // inside the address byte
  logic rd_q; // transfer is a read
  logic frn_q; // address was not ours
  logic nak_q; // master refused a read byte
  logic busy_q; // between start and stop
  logic [3:0] cnt_q; // bits seen in the current byte
  logic [7:0] sh_q; // bits shifted in, msb first
  logic rise, start, stop;
  assign rise = !scl_q && scl;
  assign start = scl_q && scl && sda_q && !sda;
  assign stop = scl_q && scl && !sda_q && sda;
  // track bits, byte slots and the kind of transfer
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      {scl_q, sda_q} <= 2'h3;
      {first_q, rd_q, frn_q, nak_q, busy_q} <= 5'h00;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      // start opens the address byte
      if (start)
      begin
        {first_q, rd_q, frn_q, nak_q, busy_q} <= 5'h11;
        cnt_q <= 4'h0;
      end
      // stop closes the transfer
      else if (stop)
        {frn_q, nak_q, busy_q} <= 3'h0;
      // acknowledge slot ends a byte
      else if (rise && cnt_q == BYTE_BITS)
      begin
        cnt_q <= 4'h0;
        first_q <= 1'b0;
        if (first_q)
        begin
          rd_q <= sh_q[0];
          frn_q <= sh_q[7:1] != DEV_ADDR;
        end
        else if (rd_q && sda)
          nak_q <= 1'b1;
      end
      // a data bit
      else if (rise)
      begin
        cnt_q <= cnt_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
      end
    end
  end
  // ==========================================================
  // assertions
  sequence low_rise_s;
    $rose(scl) && !s_sda_oe_n;
  endsequence
  sequence held_low_s;
    (!s_sda_oe_n) [*8];
  endsequence
  a_low_whole_high: assert property (low_rise_s |=> held_low_s)
    else $error("slave let go of data during clock high");
  a_addr_acked: assert property (rise && cnt_q == BYTE_BITS && first_q
    && sh_q[7:1] == DEV_ADDR |-> !sda)
    else $error("own address not acknowledged");
  a_foreign_no_ack: assert property (rise && cnt_q == BYTE_BITS
    && first_q && sh_q[7:1] != DEV_ADDR |-> sda)
    else $error("foreign address acknowledged");
  a_foreign_quiet: assert property (frn_q |-> s_sda_oe_n)
    else $error("slave drove data in a foreign transfer");
  a_nack_release: assert property (nak_q |-> s_sda_oe_n)
    else $error("slave drove data after a refused byte");
  a_write_no_drive: assert property (rise && busy_q && !first_q
    && !rd_q && cnt_q < BYTE_BITS |-> s_sda_oe_n)
    else $error("slave drove a data bit of a write");
  a_idle_released: assert property (!busy_q |-> s_sda_oe_n)
    else $error("slave drove data on an idle bus");
  a_stable_high: assert property (scl && scl_q |-> $stable(s_sda_oe_n))
    else $error("slave changed data while clock high");
endmodule : rtcisp_monitor

// File: verif/tb.sv
// self-checking bench joining both ends of the rtc two-wire port
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("unexpected %s: expected %h seen %h", nm, e, g); \
    end \
  end
module tb import rtcisp_pkg::*;;
  // ==========================================================
  // signals
  localparam int TO = 2000; // shortened bus timeout in cycles
  localparam logic [7:0] KEY = 8'hC3; // bank model: data = addr ^ key
  logic ref_clk = 1'b0, rst = 1'b1, backup = 1'b0, stall = 1'b0;
  logic wr_ready = 1'b0, cmd_valid = 1'b0, cmd_ack = 1'b0;
  rtcisp_op_e cmd_op = OP_START;
  logic [7:0] cmd_data = 8'h00, rd_addr, rd_data, wr_addr, wr_data, d;
  logic wr_valid, cmd_ready, rsp_valid, rsp_ack;
  logic [7:0] rsp_data;
  logic [8:0] ev; // expected {byte, ack}
  logic [15:0] wv; // expected {addr, data}
  logic [8:0] eq[$];
  logic [15:0] wq[$];
  logic [7:0] bad[3] = '{8'hA6, 8'h24, 8'hD5}; // foreign address bytes
  int seed = 32'h16d2, n_tests = 0, n_mismatch = 0;
  rtcisp_if link ();
  assign rd_data = rd_addr ^ KEY;
  rtcisp_dev #(.TO_CYC(TO)) rtcisp_dev_i (.ref_clk, .rst, .clk_en(1'b1),
    .backup_supply_state(backup), .link(link.dev), .wr_valid, .wr_ready,
    .wr_addr, .wr_data, .rd_addr, .rd_data);
  rtcisp_host #(.QTR_CYC(5)) rtcisp_host_i (.ref_clk, .rst, .clk_en(1'b1),
    .link(link.host), .cmd_valid, .cmd_ready, .cmd_op, .cmd_data,
    .cmd_ack, .rsp_valid, .rsp_data, .rsp_ack);
  rtcisp_monitor rtcisp_monitor_i (.ref_clk, .rst, .scl(link.scl),
    .sda(link.sda), .s_sda_oe_n(link.s_sda_oe_n));
  initial forever #2.5 ref_clk = ~ref_clk;
  // bank takes words at random unless stalled
  always @(posedge ref_clk) #1 wr_ready = !stall && 1'($random(seed));
  // ==========================================================
  // tasks
  // one host command, noting the answer of byte commands
  task automatic cmd(rtcisp_op_e op, logic [7:0] v = 8'h00,
    logic [8:0] e = 9'h000, logic a = 1'b0);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = v;
    cmd_ack = a;
    if (op == OP_WRITE || op == OP_READ)
      eq.push_back(e);
    @(posedge ref_clk);
    #1 cmd_valid = 1'b0;
    // wait until the host is idle again
    while (cmd_ready !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask : cmd
  task automatic wb(logic [7:0] v, logic a);
    cmd(OP_WRITE, v, {v, a});
  endtask : wb
  task automatic rb(logic [7:0] v, logic a);
    cmd(OP_READ, 8'h00, {v, a}, a);
  endtask : rb
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // answer and word watcher
  always @(posedge ref_clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      ev = eq.pop_front();
      `CHK("answer", ev, {rsp_data, rsp_ack})
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      wv = wq.pop_front();
      `CHK("word", wv, {wr_addr, wr_data})
    end
  end
  // watchdog
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
  // ==========================================================
  // scenarios
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 stall = 1'b1;
    // stalled bank: two words fill the buffer, the third is refused
    cmd(OP_START);
    wb(WR_ADDR_BYTE, 1'b1);
    wb(8'hFE, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($random(seed));
      wb(d, i < 2);
      if (i < 2)
        wq.push_back({8'hFE + 8'(i), d});
    end
    stall = 1'b0;
    // note the word first: the bank may take it before the byte ends
    wq.push_back({8'h00, d});
    wb(d, 1'b1);
    cmd(OP_STOP);
    // read without register address goes on after the last one
    cmd(OP_START);
    wb(RD_ADDR_BYTE, 1'b1);
    rb(8'h01 ^ KEY, 1'b1);
    rb(8'h02 ^ KEY, 1'b0);
    cmd(OP_STOP);
    // address, one word, repeated start, read onward
    cmd(OP_START);
    wb(WR_ADDR_BYTE, 1'b1);
    wb(8'h40, 1'b1);
    wq.push_back(16'h405A);
    wb(8'h5A, 1'b1);
    cmd(OP_START);
    wb(RD_ADDR_BYTE, 1'b1);
    rb(8'h41 ^ KEY, 1'b1);
    rb(8'h42 ^ KEY, 1'b0);
    cmd(OP_STOP);
    // foreign addresses get no answer
    foreach (bad[i])
    begin
      cmd(OP_START);
      wb(bad[i], 1'b0);
      wb(8'h55, 1'b0);
      cmd(OP_STOP);
    end
    // timeout in a write, then in a read
    cmd(OP_START);
    wb(WR_ADDR_BYTE, 1'b1);
    wb(8'h50, 1'b1);
    repeat (TO) @(posedge ref_clk);
    #1 wb(8'h11, 1'b0);
    cmd(OP_STOP);
    cmd(OP_START);
    wb(RD_ADDR_BYTE, 1'b1);
    rb(8'h50 ^ KEY, 1'b1);
    repeat (TO) @(posedge ref_clk);
    #1 rb(8'hFF, 1'b1);
    cmd(OP_STOP);
    // backup supply in mid-transfer, then stop and start again
    cmd(OP_START);
    wb(WR_ADDR_BYTE, 1'b1);
    backup = 1'b1;
    wb(8'h60, 1'b0);
    backup = 1'b0;
    cmd(OP_STOP);
    cmd(OP_START);
    wb(WR_ADDR_BYTE, 1'b1);
    cmd(OP_STOP);
    repeat (20) @(posedge ref_clk);
    `CHK("pending", 0, eq.size() + wq.size())
    tally_and_finish();
  end
endmodule : tb
